// ---- bdm_map.svh ----
// Constants for the background debug command unit.
// Assumes inclusion by the design files and the bench.
`ifndef BDM_MAP_SVH
`define BDM_MAP_SVH
`define CMD_NOP         4'h0
`define CMD_RD_DREG     4'h1
`define CMD_RD_AREG     4'h2
`define CMD_WR_DREG     4'h3
`define CMD_WR_AREG     4'h4
`define CMD_RD_SREG     4'h5
`define CMD_WR_SREG     4'h6
`define CMD_READ        4'h7
`define CMD_WRITE       4'h8
`define CMD_DUMP        4'h9
`define CMD_FILL        4'ha
`define CMD_GO          4'hb
`define CMD_CALL        4'hc
`define CMD_RST         4'hd
`define STAT_OK         2'h0
`define STAT_ILLEGAL    2'h1
`define STAT_BERR       2'h2
`define SREG_SOURCE_SPACE 3'h0
`define SREG_DEST_SPACE 3'h1
`define SREG_PC         3'h2
`define SREG_SR         3'h3
`define SREG_VBR        3'h4
`define SREG_SSP        3'h5
`define RESET_TIME_CYC  512
`define SOURCE_SPACE_RESET 3'h0
`define DEST_SPACE_RESET 3'h0
`define SR_RESET        16'h2700
`endif

// ---- bdm_pkg.sv ----
// Types for the background debug command unit.
// Assumes bdm_map.svh is on the include path.
package bdm_pkg;
   typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} size_t;
   typedef enum {ST_IDLE, ST_MEM, ST_CALL, ST_REPLY} state_t;
endpackage

// ---- periph_reset_pulse.sv ----
// Fixed-length pulse generator for the peripheral reset line.
// Assumes a single core clock domain.
`include "bdm_map.svh"
module periph_reset_pulse (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_reset_n,
   // Control
   input wire logic i_start,
   output logic o_reset_out,
   output logic o_busy
);
   logic [9:0] count_q;
   logic [9:0] count_d;
   logic out_q;
   logic out_d;

   always_comb begin
      count_d = count_q;
      out_d = out_q;
      if (out_q) begin
         if (count_q == 10'(`RESET_TIME_CYC - 1)) begin
            out_d = 1'b0;
            count_d = 10'h000;
         end else begin
            count_d = count_q + 10'h001;
         end
      end else if (i_start) begin
         out_d = 1'b1;
         count_d = 10'h000;
      end
   end

   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         count_q <= 10'h000;
         out_q <= 1'b0;
      end else begin
         count_q <= count_d;
         out_q <= out_d;
      end
   end

   assign o_reset_out = out_q;
   assign o_busy = out_q;

   property pulse_len_p;
      @(posedge i_clock) disable iff (!i_reset_n)
         $rose(out_q) |-> out_q [*8] ##0 (count_q == 10'h007);
   endproperty
   pulse_len_a: assert property (pulse_len_p) else $error("reset pulse ended early");
   pulse_end_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
      (out_q && count_q == 10'(`RESET_TIME_CYC - 1)) |=> !out_q)
      else $error("reset pulse length wrong");
endmodule

// ---- bdm_command_unit.sv ----
// Background debug command unit: executes host commands while the core is halted.
// Assumes commands arrive decoded from the serial link, one at a time.
`include "bdm_map.svh"
// How it works
// - Register read returns the chosen data or address register to the host.
// - Register write loads host operand into the chosen data or address register.
// - System register read returns one of six control registers; codes 6 and 7 read as zero.
// - System register write loads host operand into the addressed control register.
// - Memory read fetches sized data at 32-bit address, returned to host.
// - Memory read takes address space from the source space code register.
// - Memory write stores operand at address, space from destination space code.
// - Memory read sets block start; each dump returns next item.
// - Memory write sets block start; each fill stores next operand.
// - Resume flushes the pipeline and continues at the current program counter.
// - Patch pushes program counter on the stack, then runs patch code.
// - Peripheral reset drives the external reset line for 512 cycles.
// - Peripheral reset leaves the core registers and state untouched.
// - No-operation changes nothing and acts as a null command.
module bdm_command_unit
   import bdm_pkg::*;
(
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_reset_n,
   // Command from the serial link
   input wire logic i_cmd_valid,
   input wire logic [3:0] i_cmd_code,
   input wire logic [2:0] i_cmd_reg,
   input wire logic [1:0] i_cmd_size,
   input wire logic [31:0] i_cmd_addr,
   input wire logic [31:0] i_cmd_data,
   output logic o_cmd_ready,
   // Answer to the serial link
   output logic o_resp_valid,
   output logic [1:0] o_resp_status,
   output logic [31:0] o_resp_data,
   // Memory port
   output logic o_mem_req,
   output logic o_mem_write,
   output logic [31:0] o_mem_addr,
   output logic [2:0] o_mem_space,
   output logic [1:0] o_mem_size,
   output logic [31:0] o_mem_wdata,
   input wire logic i_mem_ack,
   input wire logic i_mem_err,
   input wire logic [31:0] i_mem_rdata,
   // Core control
   output logic o_pipe_flush,
   output logic o_resume,
   output logic [31:0] o_pc,
   output logic o_periph_reset
);
   state_t state_q, state_d;
   logic [31:0] dreg_q [8];
   logic [31:0] areg_q [8];
   logic [31:0] dreg_d [8];
   logic [31:0] areg_d [8];
   logic [2:0] source_space_code_reg_q, source_space_code_reg_d;
   logic [2:0] dest_space_code_reg_q, dest_space_code_reg_d;
   logic [31:0] pc_q, pc_d, vbr_q, vbr_d, ssp_q, ssp_d;
   logic [15:0] sr_q, sr_d;
   logic [31:0] blk_addr_q, blk_addr_d;
   logic [1:0] blk_size_q, blk_size_d;
   logic mem_req_q, mem_req_d, mem_wr_q, mem_wr_d;
   logic [31:0] mem_addr_q, mem_addr_d, mem_wdata_q, mem_wdata_d;
   logic [2:0] mem_space_q, mem_space_d;
   logic [1:0] mem_size_q, mem_size_d;
   logic resp_v_q, resp_v_d;
   logic [1:0] resp_st_q, resp_st_d;
   logic [31:0] resp_data_q, resp_data_d;
   logic flush_q, flush_d, resume_q, resume_d;
   logic rst_start, rst_busy;

   function automatic logic [31:0] size_step(input logic [1:0] sz);
      case (sz)
         2'h0: size_step = 32'h0000_0001;
         2'h1: size_step = 32'h0000_0002;
         default: size_step = 32'h0000_0004;
      endcase
   endfunction

   function automatic logic [31:0] sreg_value(input logic [2:0] sel, input logic [2:0] src_sp,
      input logic [2:0] dst_sp, input logic [31:0] pc, input logic [15:0] sr,
      input logic [31:0] vbr, input logic [31:0] ssp);
      case (sel)
         `SREG_SOURCE_SPACE: sreg_value = {29'h0, src_sp};
         `SREG_DEST_SPACE: sreg_value = {29'h0, dst_sp};
         `SREG_PC: sreg_value = pc;
         `SREG_SR: sreg_value = {16'h0, sr};
         `SREG_VBR: sreg_value = vbr;
         `SREG_SSP: sreg_value = ssp;
         default: sreg_value = 32'h0000_0000;
      endcase
   endfunction

   assign o_cmd_ready = (state_q == ST_IDLE) && !resp_v_q && !rst_busy;
   wire logic take = i_cmd_valid && o_cmd_ready;

   always_comb begin
      state_d = state_q;
      dreg_d = dreg_q;
      areg_d = areg_q;
      source_space_code_reg_d = source_space_code_reg_q;
      dest_space_code_reg_d = dest_space_code_reg_q;
      pc_d = pc_q;
      sr_d = sr_q;
      vbr_d = vbr_q;
      ssp_d = ssp_q;
      blk_addr_d = blk_addr_q;
      blk_size_d = blk_size_q;
      mem_req_d = mem_req_q;
      mem_wr_d = mem_wr_q;
      mem_addr_d = mem_addr_q;
      mem_wdata_d = mem_wdata_q;
      mem_space_d = mem_space_q;
      mem_size_d = mem_size_q;
      resp_v_d = 1'b0;
      resp_st_d = resp_st_q;
      resp_data_d = resp_data_q;
      flush_d = 1'b0;
      resume_d = 1'b0;
      rst_start = 1'b0;
      case (state_q)
         ST_IDLE: begin
            if (take) begin
               resp_v_d = 1'b1;
               resp_st_d = `STAT_OK;
               resp_data_d = 32'h0000_0000;
               case (i_cmd_code)
                  `CMD_NOP: ;
                  `CMD_RD_DREG: resp_data_d = dreg_q[i_cmd_reg];
                  `CMD_RD_AREG: resp_data_d = areg_q[i_cmd_reg];
                  `CMD_WR_DREG: dreg_d[i_cmd_reg] = i_cmd_data;
                  `CMD_WR_AREG: areg_d[i_cmd_reg] = i_cmd_data;
                  `CMD_RD_SREG: begin
                     resp_data_d = sreg_value(i_cmd_reg, source_space_code_reg_q,
                        dest_space_code_reg_q, pc_q, sr_q, vbr_q, ssp_q);
                  end
                  `CMD_WR_SREG: begin
                     case (i_cmd_reg)
                        `SREG_SOURCE_SPACE: source_space_code_reg_d = i_cmd_data[2:0];
                        `SREG_DEST_SPACE: dest_space_code_reg_d = i_cmd_data[2:0];
                        `SREG_PC: pc_d = i_cmd_data;
                        `SREG_SR: sr_d = i_cmd_data[15:0];
                        `SREG_VBR: vbr_d = i_cmd_data;
                        `SREG_SSP: ssp_d = i_cmd_data;
                        default: resp_st_d = `STAT_ILLEGAL;
                     endcase
                  end
                  `CMD_READ, `CMD_WRITE, `CMD_DUMP, `CMD_FILL: begin
                     resp_v_d = 1'b0;
                     state_d = ST_MEM;
                     mem_req_d = 1'b1;
                     mem_wr_d = (i_cmd_code == `CMD_WRITE) || (i_cmd_code == `CMD_FILL);
                     mem_space_d = mem_wr_d ? dest_space_code_reg_q
                        : source_space_code_reg_q;
                     mem_wdata_d = i_cmd_data;
                     if (i_cmd_code == `CMD_READ || i_cmd_code == `CMD_WRITE) begin
                        mem_addr_d = i_cmd_addr;
                        mem_size_d = i_cmd_size;
                        blk_size_d = i_cmd_size;
                     end else begin
                        mem_addr_d = blk_addr_q + size_step(blk_size_q);
                        mem_size_d = blk_size_q;
                     end
                     blk_addr_d = mem_addr_d;
                  end
                  `CMD_GO: begin
                     flush_d = 1'b1;
                     resume_d = 1'b1;
                  end
                  `CMD_CALL: begin
                     resp_v_d = 1'b0;
                     state_d = ST_CALL;
                     mem_req_d = 1'b1;
                     mem_wr_d = 1'b1;
                     mem_addr_d = areg_q[7] - 32'h0000_0004;
                     mem_space_d = dest_space_code_reg_q;
                     mem_size_d = 2'h2;
                     mem_wdata_d = pc_q;
                  end
                  `CMD_RST: rst_start = 1'b1;
                  default: resp_st_d = `STAT_ILLEGAL;
               endcase
            end
         end
         ST_MEM: begin
            if (i_mem_ack || i_mem_err) begin
               mem_req_d = 1'b0;
               resp_v_d = 1'b1;
               resp_st_d = i_mem_err ? `STAT_BERR : `STAT_OK;
               resp_data_d = mem_wr_q ? 32'h0000_0000 : i_mem_rdata;
               state_d = ST_IDLE;
            end
         end
         ST_CALL: begin
            if (i_mem_ack || i_mem_err) begin
               mem_req_d = 1'b0;
               resp_v_d = 1'b1;
               resp_st_d = i_mem_err ? `STAT_BERR : `STAT_OK;
               resp_data_d = 32'h0000_0000;
               if (!i_mem_err) begin
                  areg_d[7] = mem_addr_q;
                  ssp_d = mem_addr_q;
                  pc_d = i_cmd_data;
                  flush_d = 1'b1;
                  resume_d = 1'b1;
               end
               state_d = ST_IDLE;
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_q <= ST_IDLE;
         for (int i = 0; i < 8; i++) begin
            dreg_q[i] <= 32'h0000_0000;
            areg_q[i] <= 32'h0000_0000;
         end
         source_space_code_reg_q <= `SOURCE_SPACE_RESET;
         dest_space_code_reg_q <= `DEST_SPACE_RESET;
         pc_q <= 32'h0000_0000;
         sr_q <= `SR_RESET;
         vbr_q <= 32'h0000_0000;
         ssp_q <= 32'h0000_0000;
         blk_addr_q <= 32'h0000_0000;
         blk_size_q <= 2'h0;
         mem_req_q <= 1'b0;
         mem_wr_q <= 1'b0;
         mem_addr_q <= 32'h0000_0000;
         mem_wdata_q <= 32'h0000_0000;
         mem_space_q <= 3'h0;
         mem_size_q <= 2'h0;
         resp_v_q <= 1'b0;
         resp_st_q <= 2'h0;
         resp_data_q <= 32'h0000_0000;
         flush_q <= 1'b0;
         resume_q <= 1'b0;
      end else begin
         state_q <= state_d;
         dreg_q <= dreg_d;
         areg_q <= areg_d;
         source_space_code_reg_q <= source_space_code_reg_d;
         dest_space_code_reg_q <= dest_space_code_reg_d;
         pc_q <= pc_d;
         sr_q <= sr_d;
         vbr_q <= vbr_d;
         ssp_q <= ssp_d;
         blk_addr_q <= blk_addr_d;
         blk_size_q <= blk_size_d;
         mem_req_q <= mem_req_d;
         mem_wr_q <= mem_wr_d;
         mem_addr_q <= mem_addr_d;
         mem_wdata_q <= mem_wdata_d;
         mem_space_q <= mem_space_d;
         mem_size_q <= mem_size_d;
         resp_v_q <= resp_v_d;
         resp_st_q <= resp_st_d;
         resp_data_q <= resp_data_d;
         flush_q <= flush_d;
         resume_q <= resume_d;
      end
   end

   periph_reset_pulse u_rst (
      .i_clock(i_clock),
      .i_reset_n(i_reset_n),
      .i_start(rst_start),
      .o_reset_out(o_periph_reset),
      .o_busy(rst_busy)
   );

   assign o_resp_valid = resp_v_q;
   assign o_resp_status = resp_st_q;
   assign o_resp_data = resp_data_q;
   assign o_mem_req = mem_req_q;
   assign o_mem_write = mem_wr_q;
   assign o_mem_addr = mem_addr_q;
   assign o_mem_space = mem_space_q;
   assign o_mem_size = mem_size_q;
   assign o_mem_wdata = mem_wdata_q;
   assign o_pipe_flush = flush_q;
   assign o_resume = resume_q;
   assign o_pc = pc_q;

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_reset_n);

   sequence rd_dreg_s;
      take && i_cmd_code == `CMD_RD_DREG;
   endsequence
   reg_read_a: assert property (rd_dreg_s |=> resp_v_q &&
      resp_data_q == $past(dreg_q[i_cmd_reg])) else $error("data register read wrong");
   reg_write_a: assert property (take && i_cmd_code == `CMD_WR_AREG |=>
      areg_q[$past(i_cmd_reg)] == $past(i_cmd_data)) else $error("address write lost");
   sreg_read_a: assert property (take && i_cmd_code == `CMD_RD_SREG &&
      i_cmd_reg == `SREG_PC |=> resp_data_q == $past(pc_q)) else $error("pc read wrong");
   sreg_write_a: assert property (take && i_cmd_code == `CMD_WR_SREG &&
      i_cmd_reg == `SREG_SOURCE_SPACE |=> source_space_code_reg_q == $past(i_cmd_data[2:0]))
      else $error("source space write lost");
   read_space_a: assert property (take && i_cmd_code == `CMD_READ |=>
      mem_req_q && !mem_wr_q && mem_space_q == $past(source_space_code_reg_q))
      else $error("read space");
   write_space_a: assert property (take && i_cmd_code == `CMD_WRITE |=>
      mem_req_q && mem_wr_q && mem_space_q == $past(dest_space_code_reg_q))
      else $error("write space");
   dump_next_a: assert property (take && i_cmd_code == `CMD_DUMP |=>
      mem_addr_q == $past(blk_addr_q) + size_step($past(blk_size_q)))
      else $error("dump address not advanced");
   mem_answer_a: assert property (state_q == ST_MEM && i_mem_ack && !mem_wr_q |=>
      resp_v_q && resp_data_q == $past(i_mem_rdata)) else $error("memory read data");
   go_flush_a: assert property (take && i_cmd_code == `CMD_GO |=>
      flush_q && resume_q && pc_q == $past(pc_q)) else $error("resume without flush");
   rst_core_a: assert property (take && i_cmd_code == `CMD_RST |=>
      o_periph_reset && pc_q == $past(pc_q) && sr_q == $past(sr_q))
      else $error("core disturbed");
   nop_still_a: assert property (take && i_cmd_code == `CMD_NOP |=>
      !mem_req_q && !flush_q && pc_q == $past(pc_q)) else $error("nop changed state");
   illegal_cmd_a: assert property (take && i_cmd_code > `CMD_RST |=>
      resp_v_q && resp_st_q == `STAT_ILLEGAL && !mem_req_q) else $error("illegal accepted");
   call_push_a: assert property (take && i_cmd_code == `CMD_CALL |=>
      mem_wr_q && mem_wdata_q == $past(pc_q)) else $error("pc not pushed");
endmodule

// ---- mem_model.sv ----
// Behavioural memory that answers the debug unit's memory port.
// Assumes the unit holds its request until ack or err; waits i_wait cycles.
module mem_model #(
   parameter logic [31:0] ERR_ADDR = 32'h0000_dea0
) (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_reset_n,
   // Request side
   input wire logic i_req,
   input wire logic i_write,
   input wire logic [31:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wait,
   // Answer side
   output logic o_ack,
   output logic o_err,
   output logic [31:0] o_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] mem [logic [31:0]];
   logic [31:0] last;
   int cnt;
   logic done;
   always @(negedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_ack <= 1'b0;
         o_err <= 1'b0;
         o_rdata <= 32'h0;
         last = 32'h0;
         cnt = 0;
         done = 1'b0;
      end else begin
         o_ack <= 1'b0;
         o_err <= 1'b0;
         // Released data shows the inverse, never a stale copy
         o_rdata <= ~last;
         if (i_req !== 1'b1) begin
            done = 1'b0;
            cnt = 0;
         end else if (!done && cnt < i_wait) begin
            cnt++;
         end else if (!done) begin
            done = 1'b1;
            if (i_addr === ERR_ADDR) begin
               o_err <= 1'b1;
            end else begin
               o_ack <= 1'b1;
               if (i_write === 1'b1) begin
                  mem[i_addr] = i_wdata;
               end else begin
                  last = mem.exists(i_addr) ? mem[i_addr] : ~i_addr;
                  o_rdata <= last;
               end
            end
         end
      end
   end
endmodule

// ---- testbench.sv ----
// Self-checking bench for the background debug command unit.
// Assumes mem_model.sv and the design files are compiled first.
`include "bdm_map.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import bdm_pkg::*;
   logic i_clock = 1'b0;
   logic i_reset_n = 1'b0;
   logic cmd_valid = 1'b0, cmd_ready, resp_valid, mem_req, mem_write, mem_ack, mem_err;
   logic [3:0] cmd_code = 4'h0, mem_wait = 4'h0;
   logic [2:0] cmd_reg = 3'h0, mem_space;
   logic [1:0] cmd_size = 2'h0, resp_status, mem_size;
   logic [31:0] cmd_addr = 32'h0, cmd_data = 32'h0, resp_data, mem_addr, mem_wdata, mem_rdata;
   logic pipe_flush, resume, periph_reset;
   logic [31:0] pc;
   logic [31:0] rsp_data, m_addr, m_wdata;
   logic [1:0] rsp_stat, m_size;
   logic [2:0] m_space;
   int errors = 0, cmp_count = 0, m_cnt = 0, fl_cnt = 0, rs_cnt = 0, pr_cnt = 0;
   localparam logic [31:0] BAD = 32'h0000_dea0;
   always #12.5 i_clock = ~i_clock;
   bdm_command_unit bdm_command_unit_i (.i_clock(i_clock), .i_reset_n(i_reset_n),
      .i_cmd_valid(cmd_valid), .i_cmd_code(cmd_code), .i_cmd_reg(cmd_reg),
      .i_cmd_size(cmd_size), .i_cmd_addr(cmd_addr), .i_cmd_data(cmd_data),
      .o_cmd_ready(cmd_ready), .o_resp_valid(resp_valid), .o_resp_status(resp_status),
      .o_resp_data(resp_data), .o_mem_req(mem_req), .o_mem_write(mem_write),
      .o_mem_addr(mem_addr), .o_mem_space(mem_space), .o_mem_size(mem_size),
      .o_mem_wdata(mem_wdata), .i_mem_ack(mem_ack), .i_mem_err(mem_err),
      .i_mem_rdata(mem_rdata), .o_pipe_flush(pipe_flush), .o_resume(resume), .o_pc(pc),
      .o_periph_reset(periph_reset));
   mem_model #(.ERR_ADDR(BAD)) mem_model_i (.i_clock(i_clock), .i_reset_n(i_reset_n),
      .i_req(mem_req), .i_write(mem_write), .i_addr(mem_addr), .i_wdata(mem_wdata),
      .i_wait(mem_wait), .o_ack(mem_ack), .o_err(mem_err), .o_rdata(mem_rdata));
   // Snoop completed memory cycles and control pulses
   always @(posedge i_clock) begin
      if (mem_req === 1'b1 && (mem_ack === 1'b1 || mem_err === 1'b1)) begin
         m_addr = mem_addr;
         m_wdata = mem_wdata;
         m_space = mem_space;
         m_size = mem_size;
         m_cnt++;
      end
      if (pipe_flush === 1'b1) fl_cnt++;
      if (resume === 1'b1) rs_cnt++;
      if (periph_reset === 1'b1) pr_cnt++;
   end
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         errors++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_stat(input logic [1:0] e);
      chk_word("status", {30'h0, e}, {30'h0, rsp_stat});
   endtask
   // One command, then wait for its answer before the next
   task automatic send(input logic [3:0] c, input logic [2:0] r, input logic [1:0] s,
      input logic [31:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(negedge i_clock);
      while (cmd_ready !== 1'b1 && n < 1000) begin
         @(negedge i_clock);
         n++;
      end
      {cmd_valid, cmd_code, cmd_reg, cmd_size, cmd_addr, cmd_data} = {1'b1, c, r, s, a, d};
      @(negedge i_clock);
      cmd_valid = 1'b0;
      while (resp_valid !== 1'b1 && n < 2000) begin
         @(negedge i_clock);
         n++;
      end
      if (n >= 1000) chk_word("answer wait", 32'h0, 32'h1);
      rsp_stat = resp_status;
      rsp_data = resp_data;
   endtask
   task automatic t_regs();
      for (int i = 0; i < 8; i++) begin
         send(`CMD_WR_DREG, 3'(i), 2'h0, 32'h0, 32'h1111_0000 + i);
         send(`CMD_WR_AREG, 3'(i), 2'h0, 32'h0, 32'h2222_0000 + i);
      end
      for (int i = 0; i < 8; i++) begin
         send(`CMD_RD_DREG, 3'(i), 2'h0, 32'h0, 32'h0);
         chk_word("data reg", 32'h1111_0000 + i, rsp_data);
         send(`CMD_RD_AREG, 3'(i), 2'h0, 32'h0, 32'h0);
         chk_word("addr reg", 32'h2222_0000 + i, rsp_data);
      end
   endtask
   task automatic t_sregs();
      logic [31:0] rv [4];
      rv = '{32'h0, 32'h0, 32'h0, {16'h0, `SR_RESET}};
      for (int i = 0; i < 4; i++) begin
         send(`CMD_RD_SREG, 3'(i), 2'h0, 32'h0, 32'h0);
         chk_word("system reg reset", rv[i], rsp_data);
      end
      send(`CMD_WR_SREG, `SREG_VBR, 2'h0, 32'h0, 32'h0000_4000);
      send(`CMD_RD_SREG, `SREG_VBR, 2'h0, 32'h0, 32'h0);
      chk_word("vbr", 32'h0000_4000, rsp_data);
      send(`CMD_WR_SREG, 3'h7, 2'h0, 32'h0, 32'h1);
      chk_stat(`STAT_ILLEGAL);
   endtask
   task automatic t_mem();
      send(`CMD_WR_SREG, `SREG_SOURCE_SPACE, 2'h0, 32'h0, 32'h5);
      send(`CMD_WR_SREG, `SREG_DEST_SPACE, 2'h0, 32'h0, 32'h3);
      send(`CMD_WRITE, 3'h0, 2'h2, 32'h0000_0100, 32'hcafe_0001);
      chk_word("write addr", 32'h0000_0100, m_addr);
      chk_word("write space", 32'h3, {29'h0, m_space});
      send(`CMD_READ, 3'h0, 2'h2, 32'h0000_0100, 32'h0);
      chk_word("read data", 32'hcafe_0001, rsp_data);
      chk_word("read space", 32'h5, {29'h0, m_space});
      send(`CMD_READ, 3'h0, 2'h0, 32'h0000_0101, 32'h0);
      chk_word("read size", 32'h0, {30'h0, m_size});
      chk_word("read byte addr", 32'h0000_0101, m_addr);
      send(`CMD_READ, 3'h0, 2'h2, BAD, 32'h0);
      chk_stat(`STAT_BERR);
   endtask
   task automatic t_block();
      mem_wait = 4'h2;
      send(`CMD_WRITE, 3'h0, 2'h2, 32'h0000_0200, 32'h0bad_0000);
      for (int k = 1; k < 4; k++) begin
         send(`CMD_FILL, 3'h0, 2'h0, 32'h0, 32'h0bad_0000 + k);
         chk_word("fill addr", 32'h0000_0200 + 4 * k, m_addr);
      end
      send(`CMD_READ, 3'h0, 2'h2, 32'h0000_0200, 32'h0);
      chk_word("dump first", 32'h0bad_0000, rsp_data);
      for (int k = 1; k < 4; k++) begin
         send(`CMD_DUMP, 3'h0, 2'h0, 32'h0, 32'h0);
         chk_word("dump data", 32'h0bad_0000 + k, rsp_data);
      end
      send(`CMD_WRITE, 3'h0, 2'h1, 32'h0000_0300, 32'h1234);
      send(`CMD_FILL, 3'h0, 2'h0, 32'h0, 32'h5678);
      chk_word("word fill addr", 32'h0000_0302, m_addr);
      mem_wait = 4'h0;
   endtask
   task automatic t_flow();
      int f0, r0;
      send(`CMD_WR_SREG, `SREG_PC, 2'h0, 32'h0, 32'h0000_1000);
      f0 = fl_cnt;
      r0 = rs_cnt;
      send(`CMD_GO, 3'h0, 2'h0, 32'h0, 32'h0);
      // Pulses are counted at the next rising edge
      @(negedge i_clock);
      chk_word("go flush", 32'h1, 32'(fl_cnt - f0));
      chk_word("go resume", 32'h1, 32'(rs_cnt - r0));
      chk_word("pc pin", 32'h0000_1000, pc);
      send(`CMD_RD_SREG, `SREG_PC, 2'h0, 32'h0, 32'h0);
      chk_word("pc after go", 32'h0000_1000, rsp_data);
      send(`CMD_WR_AREG, 3'h7, 2'h0, 32'h0, 32'h0000_0800);
      send(`CMD_CALL, 3'h0, 2'h0, 32'h0, 32'h0000_3000);
      chk_word("push addr", 32'h0000_07fc, m_addr);
      chk_word("push data", 32'h0000_1000, m_wdata);
      chk_word("push space", 32'h3, {29'h0, m_space});
      send(`CMD_RD_SREG, `SREG_PC, 2'h0, 32'h0, 32'h0);
      chk_word("pc after call", 32'h0000_3000, rsp_data);
      send(`CMD_RD_SREG, `SREG_SSP, 2'h0, 32'h0, 32'h0);
      chk_word("stack after call", 32'h0000_07fc, rsp_data);
      send(`CMD_RD_AREG, 3'h7, 2'h0, 32'h0, 32'h0);
      chk_word("a7 after call", 32'h0000_07fc, rsp_data);
   endtask
   task automatic t_rst();
      int p0, n;
      p0 = pr_cnt;
      n = 0;
      send(`CMD_RST, 3'h0, 2'h0, 32'h0, 32'h0);
      chk_stat(`STAT_OK);
      chk_word("ready in pulse", 32'h0, {31'h0, cmd_ready});
      while (cmd_ready !== 1'b1 && n < 700) begin
         @(negedge i_clock);
         n++;
      end
      chk_word("reset cycles", 32'd512, 32'(pr_cnt - p0));
      send(`CMD_RD_DREG, 3'h0, 2'h0, 32'h0, 32'h0);
      chk_word("d0 after reset", 32'h1111_0000, rsp_data);
   endtask
   task automatic t_null();
      int m0;
      m0 = m_cnt;
      send(`CMD_NOP, 3'h1, 2'h0, 32'h0, 32'hffff_ffff);
      chk_stat(`STAT_OK);
      for (int c = 14; c < 16; c++) begin
         send(4'(c), 3'h1, 2'h0, 32'h0, 32'hffff_ffff);
         chk_stat(`STAT_ILLEGAL);
      end
      send(`CMD_RD_DREG, 3'h1, 2'h0, 32'h0, 32'h0);
      chk_word("d1 unchanged", 32'h1111_0001, rsp_data);
      chk_word("no memory cycles", 32'h0, 32'(m_cnt - m0));
   endtask
   initial begin
      #(25.0 * 20000);
      errors++;
      final_report();
   end
   initial begin
      repeat (10) @(negedge i_clock);
      i_reset_n = 1'b1;
      t_sregs();
      t_regs();
      t_mem();
      t_block();
      t_flow();
      t_rst();
      t_null();
      final_report();
   end
endmodule
